// file: hw/rtc_cal_alarm.sv
/*
 * Month, year and century counters with the alarm set-point registers,
 * reached over AHB-Lite, and the alarm flag that compares them.
 * Assumes the seconds to day counters sit outside and give the current
 * time, an increment strobe and a day roll-over strobe on CLK.
 */
// Design decision made here: register access over AHB-Lite.
// Summary of operation
// R1: Decimal month: tens digit 0..1 in bits 7:4, units 0..9 in 3:0.
// R2: Binary month: whole byte, one through twelve.
// R3: Decimal year: two digits 0..9, tens high nibble, units low.
// R4: Binary year: byte zero through ninety-nine.
// R5: Decimal century: tens and units digits 0..9 in the two nibbles.
// R6: Binary century: byte zero through ninety-nine.
// R7: Reset leaves month, year, century and alarm time set-points unchanged.
// R8: Month, year, century writable only while unlocked; locked writes ignored.
// R9: Decimal alarm seconds: tens 0..5 high nibble, units 0..9 low.
// R10: Binary alarm seconds and minutes: byte zero through fifty-nine.
// R11: Decimal alarm minutes: tens 0..5 high nibble, units 0..9 low.
// R12: Decimal alarm hours: tens 0..2 high nibble, units 0..9 low.
// R13: Binary alarm hours: byte zero through twenty-three.
// R14: Alarm seconds, minutes, hours writable at all times.
// R15: Alarm weekday upper nibble reads zero; low nibble kept, unlocked writes.
// R16: Encoding bit selects packed decimal or binary for all registers.
// R17: Unlock bit one opens count writes and halts counting.
// R18: Four alarm comparison enables, all cleared by reset.
// R19: Control read clears flag; flag evaluated on increment and relock.
// R20: Alarm when every enabled field equals its current count.
// R21: Day roll-over advances month, twelve wraps to one, year, century.
`timescale 1ns/1ns
`default_nettype none

module rtc_cal_alarm (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    input  wire logic        COUNT_TICK,
    input  wire logic        DAY_WRAP,
    input  wire logic [7:0]  SEC_NOW,
    input  wire logic [7:0]  MIN_NOW,
    input  wire logic [7:0]  HOUR_NOW,
    input  wire logic [3:0]  WEEKDAY_NOW,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             ALARM_FLAG,
    output logic             BCD_MODE,
    output logic             UNLOCKED,
    output logic      [7:0]  MONTH_COUNT,
    output logic      [7:0]  YEAR_COUNT,
    output logic      [7:0]  EPOCH_COUNT
);

    // Values that survive reset; this group has no reset at all.
    typedef struct packed {
        logic [7:0] mth_count;
        logic [7:0] year_count;
        logic [7:0] epoch_count;
        logic [7:0] alarm_s_setpoint;
        logic [7:0] alarm_m_setpoint;
        logic [7:0] alarm_hour_setpoint;
        logic [3:0] alarm_weekday;
        logic       bcd;
    } keep_t;

    // Control state, cleared by reset except hreadyout, which resets to one.
    typedef struct packed {
        logic        dphase_wr;
        logic [7:0]  dphase_idx;
        logic        unlock;
        logic [3:0]  alarm_en;
        logic        alarm_flag;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ctl_t;

    keep_t keep_reg;
    keep_t keep_next;
    ctl_t  ctl_reg;
    ctl_t  ctl_next;

    // Advances a count by one in the selected encoding, wrapping at its end.
    function automatic logic [7:0] step_count(
        input logic [7:0] val,
        input logic       bcd,
        input logic [7:0] first,
        input logic [7:0] last_bin,
        input logic [7:0] last_bcd
    );
        logic [7:0] res;
        if (val == (bcd ? last_bcd : last_bin)) begin
            res = first;
        end else if (bcd && val[3:0] == rtc_cal_pkg::BCD_UNITS_MAX) begin
            res = {val[7:4] + 4'h1, 4'h0};
        end else begin
            res = val + 8'h01;
        end
        return res;
    endfunction : step_count

    logic       addr_hit;
    logic [7:0] addr_idx;
    logic       rd_ctrl;
    logic       wr_en;
    logic [7:0] wdat;
    logic       relock;
    logic       evaluate;
    logic       match;
    logic       mth_last;
    logic       year_last;
    logic [7:0] rdat;

    always_comb begin
        keep_next = keep_reg;
        ctl_next  = ctl_reg;
        addr_idx  = HADDR[rtc_cal_pkg::IDX_MSB:rtc_cal_pkg::IDX_LSB];
        addr_hit  = HSEL && HREADY && HTRANS == rtc_cal_pkg::HTRANS_NONSEQ
                    && HSIZE == rtc_cal_pkg::HSIZE_WORD
                    && HADDR[31:10] == 22'h00_0000 && HADDR[1:0] == 2'b00;
        rd_ctrl   = addr_hit && !HWRITE && addr_idx == rtc_cal_pkg::IDX_CTRL;
        wr_en     = ctl_reg.dphase_wr;
        wdat      = HWDATA[7:0];
        relock    = 1'b0;

        // Register writes land in the data phase of the transfer.
        if (wr_en) begin
            unique case (ctl_reg.dphase_idx)
                rtc_cal_pkg::IDX_MONTH: begin
                    if (ctl_reg.unlock) begin
                        keep_next.mth_count = wdat; // R8
                    end
                end
                rtc_cal_pkg::IDX_YEAR: begin
                    if (ctl_reg.unlock) begin
                        keep_next.year_count = wdat; // R8
                    end
                end
                rtc_cal_pkg::IDX_EPOCH: begin
                    if (ctl_reg.unlock) begin
                        keep_next.epoch_count = wdat; // R8
                    end
                end
                rtc_cal_pkg::IDX_ALM_S: keep_next.alarm_s_setpoint = wdat; // R9 R10 R14
                rtc_cal_pkg::IDX_ALM_M: keep_next.alarm_m_setpoint = wdat; // R10 R11 R14
                rtc_cal_pkg::IDX_ALM_H: keep_next.alarm_hour_setpoint = wdat; // R12 R13 R14
                rtc_cal_pkg::IDX_ALM_WD: begin
                    if (ctl_reg.unlock) begin
                        keep_next.alarm_weekday = wdat[3:0]; // R15
                    end
                end
                rtc_cal_pkg::IDX_ALM_EN: ctl_next.alarm_en = wdat[3:0]; // R18
                rtc_cal_pkg::IDX_CTRL: begin
                    keep_next.bcd  = wdat[rtc_cal_pkg::CTRL_BCD_BIT]; // R16
                    ctl_next.unlock = wdat[rtc_cal_pkg::CTRL_UNLOCK_BIT]; // R17
                    relock = ctl_reg.unlock && !wdat[rtc_cal_pkg::CTRL_UNLOCK_BIT];
                end
                default: begin
                end
            endcase
        end

        // Calendar roll-over only while the counters run.
        mth_last  = keep_reg.mth_count == (keep_reg.bcd ? rtc_cal_pkg::MONTH_LAST_BCD
                                                        : rtc_cal_pkg::MONTH_LAST_BIN);
        year_last = keep_reg.year_count == (keep_reg.bcd ? rtc_cal_pkg::YEAR_LAST_BCD
                                                         : rtc_cal_pkg::YEAR_LAST_BIN);
        if (DAY_WRAP && !ctl_reg.unlock) begin // R17
            keep_next.mth_count = step_count(keep_reg.mth_count, keep_reg.bcd,
                rtc_cal_pkg::MONTH_FIRST, rtc_cal_pkg::MONTH_LAST_BIN,
                rtc_cal_pkg::MONTH_LAST_BCD); // R1 R2 R21
            if (mth_last) begin
                keep_next.year_count = step_count(keep_reg.year_count, keep_reg.bcd,
                    rtc_cal_pkg::YEAR_FIRST, rtc_cal_pkg::YEAR_LAST_BIN,
                    rtc_cal_pkg::YEAR_LAST_BCD); // R3 R4 R21
                if (year_last) begin
                    keep_next.epoch_count = step_count(keep_reg.epoch_count,
                        keep_reg.bcd, rtc_cal_pkg::YEAR_FIRST,
                        rtc_cal_pkg::YEAR_LAST_BIN,
                        rtc_cal_pkg::YEAR_LAST_BCD); // R5 R6 R21
                end
            end
        end

        // Both sides hold the same encoding, so a byte compare serves either mode.
        match = (ctl_reg.alarm_en != 4'h0)
            && (!ctl_reg.alarm_en[rtc_cal_pkg::EN_S_BIT]
                || SEC_NOW == keep_reg.alarm_s_setpoint)
            && (!ctl_reg.alarm_en[rtc_cal_pkg::EN_M_BIT]
                || MIN_NOW == keep_reg.alarm_m_setpoint)
            && (!ctl_reg.alarm_en[rtc_cal_pkg::EN_H_BIT]
                || HOUR_NOW == keep_reg.alarm_hour_setpoint)
            && (!ctl_reg.alarm_en[rtc_cal_pkg::EN_WD_BIT]
                || WEEKDAY_NOW == keep_reg.alarm_weekday); // R20
        evaluate = (COUNT_TICK && !ctl_reg.unlock) || relock; // R19
        // A set in the same cycle as the clearing read is kept.
        ctl_next.alarm_flag = (ctl_reg.alarm_flag && !rd_ctrl)
                              || (evaluate && match); // R19

        // Read data is sampled from post-write values, so a read straight
        // after a write returns the new contents.
        unique case (addr_idx)
            rtc_cal_pkg::IDX_MONTH:  rdat = keep_next.mth_count;
            rtc_cal_pkg::IDX_YEAR:   rdat = keep_next.year_count;
            rtc_cal_pkg::IDX_EPOCH:  rdat = keep_next.epoch_count;
            rtc_cal_pkg::IDX_ALM_S:  rdat = keep_next.alarm_s_setpoint;
            rtc_cal_pkg::IDX_ALM_M:  rdat = keep_next.alarm_m_setpoint;
            rtc_cal_pkg::IDX_ALM_H:  rdat = keep_next.alarm_hour_setpoint;
            rtc_cal_pkg::IDX_ALM_WD: rdat = {4'h0, keep_next.alarm_weekday}; // R15
            rtc_cal_pkg::IDX_ALM_EN: rdat = {4'h0, ctl_next.alarm_en};
            rtc_cal_pkg::IDX_CTRL:   rdat = {ctl_reg.alarm_flag, 1'b0,
                                             keep_next.bcd, 4'h0, ctl_next.unlock};
            default:                 rdat = 8'h00;
        endcase

        ctl_next.dphase_wr  = addr_hit && HWRITE;
        ctl_next.dphase_idx = addr_idx;
        ctl_next.hrdata     = (addr_hit && !HWRITE) ? {24'h00_0000, rdat} : 32'h0000_0000;
        // Every transfer ends with zero wait states and an OKAY answer, since no
        // register here needs more than one cycle to be read or written.
        ctl_next.hreadyout  = 1'b1;
        ctl_next.hresp      = 1'b0;
    end

    // Deliberately no reset: these values must ride through a device reset.
    always_ff @(posedge CLK) begin
        if (CE) begin
            keep_reg <= keep_next; // R7
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_reg <= '{dphase_wr: 1'b0, dphase_idx: 8'h00,
                         unlock: rtc_cal_pkg::UNLOCK_RESET,
                         alarm_en: rtc_cal_pkg::ALM_EN_RESET, // R18
                         alarm_flag: 1'b0, hrdata: 32'h0000_0000,
                         hreadyout: 1'b1, hresp: 1'b0};
        end else if (CE) begin
            ctl_reg <= ctl_next;
        end
    end

    assign HRDATA      = ctl_reg.hrdata;
    assign HREADYOUT   = ctl_reg.hreadyout;
    assign HRESP       = ctl_reg.hresp;
    assign ALARM_FLAG  = ctl_reg.alarm_flag;
    assign UNLOCKED    = ctl_reg.unlock;
    assign BCD_MODE    = keep_reg.bcd;
    assign MONTH_COUNT = keep_reg.mth_count;
    assign YEAR_COUNT  = keep_reg.year_count;
    assign EPOCH_COUNT = keep_reg.epoch_count;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    logic wr_month;
    logic wr_alm_s;
    assign wr_month = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_MONTH;
    assign wr_alm_s = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_ALM_S;

    // Data-phase write strobes for the remaining registers, gated by the enable.
    logic wr_year;
    logic wr_epoch;
    logic wr_alm_m;
    logic wr_alm_h;
    logic wr_alm_wd;
    logic wr_alm_en;
    logic wr_ctrl;
    assign wr_year   = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_YEAR;
    assign wr_epoch  = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_EPOCH;
    assign wr_alm_m  = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_ALM_M;
    assign wr_alm_h  = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_ALM_H;
    assign wr_alm_wd = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_ALM_WD;
    assign wr_alm_en = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_ALM_EN;
    assign wr_ctrl   = CE && wr_en && ctl_reg.dphase_idx == rtc_cal_pkg::IDX_CTRL;

    a_locked_month_kept: assert property ( // R8
        wr_month && !ctl_reg.unlock && !DAY_WRAP |=> $stable(keep_reg.mth_count))
        else $error("month changed by a locked write");

    a_unlocked_month_set: assert property ( // R8
        wr_month && ctl_reg.unlock |=> keep_reg.mth_count == $past(HWDATA[7:0]))
        else $error("unlocked month write lost");

    a_alarm_s_always: assert property ( // R14
        wr_alm_s |=> keep_reg.alarm_s_setpoint == $past(HWDATA[7:0]))
        else $error("alarm seconds write lost");

    a_weekday_high_zero: assert property ( // R15
        CE && addr_hit && !HWRITE && addr_idx == rtc_cal_pkg::IDX_ALM_WD
        |=> HRDATA[7:4] == 4'h0)
        else $error("weekday upper nibble not zero");

    a_flag_read_clear: assert property ( // R19
        CE && rd_ctrl && !evaluate |=> !ALARM_FLAG)
        else $error("alarm flag survived a control read");

    a_flag_set_match: assert property ( // R20
        CE && evaluate && match |=> ALARM_FLAG ##1 (!CE || ALARM_FLAG || $past(rd_ctrl)))
        else $error("alarm flag not set on match");

    a_no_enable_no_alarm: assert property ( // R20
        CE && ctl_reg.alarm_en == 4'h0 && !ALARM_FLAG |=> !ALARM_FLAG)
        else $error("alarm with no comparison enabled");

    a_month_wraps: assert property ( // R21
        CE && DAY_WRAP && !ctl_reg.unlock && !wr_en && mth_last
        |=> MONTH_COUNT == rtc_cal_pkg::MONTH_FIRST && !$stable(YEAR_COUNT))
        else $error("month did not wrap into a new year");

    a_bcd_month_carry: assert property ( // R1
        CE && DAY_WRAP && !ctl_reg.unlock && !wr_en && keep_reg.bcd
        && keep_reg.mth_count == 8'h09 |=> MONTH_COUNT == 8'h10)
        else $error("decimal month carry wrong");

    a_halt_unlocked: assert property ( // R17
        CE && ctl_reg.unlock && !wr_en |=> $stable(MONTH_COUNT))
        else $error("month counted while unlocked");

    a_locked_year_kept: assert property ( // R8
        wr_year && !ctl_reg.unlock && !DAY_WRAP |=> $stable(YEAR_COUNT))
        else $error("year changed by a locked write");

    a_unlocked_year_set: assert property ( // R8
        wr_year && ctl_reg.unlock |=> YEAR_COUNT == $past(HWDATA[7:0]))
        else $error("unlocked year write lost");

    a_locked_epoch_kept: assert property ( // R8
        wr_epoch && !ctl_reg.unlock && !DAY_WRAP |=> $stable(EPOCH_COUNT))
        else $error("century changed by a locked write");

    a_unlocked_epoch_set: assert property ( // R8
        wr_epoch && ctl_reg.unlock |=> EPOCH_COUNT == $past(HWDATA[7:0]))
        else $error("unlocked century write lost");

    a_alarm_m_always: assert property ( // R14
        wr_alm_m |=> keep_reg.alarm_m_setpoint == $past(HWDATA[7:0]))
        else $error("alarm minutes write lost");

    a_alarm_h_always: assert property ( // R14
        wr_alm_h |=> keep_reg.alarm_hour_setpoint == $past(HWDATA[7:0]))
        else $error("alarm hours write lost");

    a_locked_weekday_kept: assert property ( // R15
        wr_alm_wd && !ctl_reg.unlock |=> $stable(keep_reg.alarm_weekday))
        else $error("alarm weekday changed by a locked write");

    a_enables_written: assert property ( // R18
        wr_alm_en |=> ctl_reg.alarm_en == $past(HWDATA[3:0]))
        else $error("alarm enables write lost");

    a_ctrl_bcd_written: assert property ( // R16
        wr_ctrl |=> BCD_MODE == $past(HWDATA[rtc_cal_pkg::CTRL_BCD_BIT]))
        else $error("encoding select write lost");

    a_ctrl_unlock_written: assert property ( // R17
        wr_ctrl |=> UNLOCKED == $past(HWDATA[rtc_cal_pkg::CTRL_UNLOCK_BIT]))
        else $error("unlock bit write lost");

    a_flag_needs_eval: assert property ( // R19
        CE && !evaluate && !ALARM_FLAG |=> !ALARM_FLAG)
        else $error("alarm flag set without an evaluation");

    c_relock_alarm: cover property (CE && relock && match);
    c_year_wrap: cover property (CE && DAY_WRAP && !ctl_reg.unlock && mth_last && year_last);
    c_read_clears: cover property (ALARM_FLAG && CE && rd_ctrl);
    c_set_beats_clear: cover property (CE && rd_ctrl && evaluate && match);

endmodule : rtc_cal_alarm

`default_nettype wire

// file: hw/rtc_cal_pkg.sv
/*
 * Constants for the calendar count and alarm set-point register block.
 * Assumes a 32-bit AHB-Lite slave with word-aligned registers.
 */
package rtc_cal_pkg;

    // Register indices. The byte address of a register is four times its index.
    localparam logic [7:0] IDX_MONTH   = 8'he5;
    localparam logic [7:0] IDX_YEAR    = 8'he6;
    localparam logic [7:0] IDX_EPOCH   = 8'he7;
    localparam logic [7:0] IDX_ALM_S   = 8'he8;
    localparam logic [7:0] IDX_ALM_M   = 8'he9;
    localparam logic [7:0] IDX_ALM_H   = 8'hea;
    localparam logic [7:0] IDX_ALM_WD  = 8'heb;
    localparam logic [7:0] IDX_ALM_EN  = 8'hec;
    localparam logic [7:0] IDX_CTRL    = 8'hed;

    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // Control register fields.
    localparam int CTRL_FLAG_BIT   = 7;
    localparam int CTRL_BCD_BIT    = 5;
    localparam int CTRL_UNLOCK_BIT = 0;

    // Alarm enable register fields.
    localparam int EN_WD_BIT = 3;
    localparam int EN_H_BIT  = 2;
    localparam int EN_M_BIT  = 1;
    localparam int EN_S_BIT  = 0;

    localparam logic [3:0] ALM_EN_RESET = 4'h0;
    localparam logic       UNLOCK_RESET = 1'b0;

    // Count limits in both encodings.
    localparam logic [7:0] MONTH_FIRST    = 8'h01;
    localparam logic [7:0] MONTH_LAST_BIN = 8'h0c;
    localparam logic [7:0] MONTH_LAST_BCD = 8'h12;
    localparam logic [7:0] YEAR_FIRST     = 8'h00;
    localparam logic [7:0] YEAR_LAST_BIN  = 8'h63;
    localparam logic [7:0] YEAR_LAST_BCD  = 8'h99;
    localparam logic [3:0] BCD_UNITS_MAX  = 4'h9;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

endpackage : rtc_cal_pkg

// file: sim/tb.sv
/*
 * Self-checking bench for the calendar count and alarm set-point block.
 * Assumes the block is the only AHB-Lite slave, so its HREADYOUT is the bus HREADY.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end

module tb;
    logic        CLK         = 1'b0;
    logic        RESET_N     = 1'b0;
    logic        CE          = 1'b1;
    logic        HSEL        = 1'b0;
    logic [31:0] HADDR       = {32{1'b0}};
    logic [1:0]  HTRANS      = 2'b00;
    logic        HWRITE      = 1'b0;
    logic [2:0]  HSIZE       = rtc_cal_pkg::HSIZE_WORD;
    logic [31:0] HWDATA      = {32{1'b0}};
    logic        COUNT_TICK  = 1'b0;
    logic        DAY_WRAP    = 1'b0;
    logic [7:0]  SEC_NOW     = 8'h00;
    logic [7:0]  MIN_NOW     = 8'h00;
    logic [7:0]  HOUR_NOW    = 8'h00;
    logic [3:0]  WEEKDAY_NOW = 4'h1;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic        ALARM_FLAG;
    logic        BCD_MODE;
    logic        UNLOCKED;
    logic [7:0]  MONTH_COUNT;
    logic [7:0]  YEAR_COUNT;
    logic [7:0]  EPOCH_COUNT;
    int          err_count = 0;
    int          tests_run = 0;
    logic        bcd;
    logic [7:0]  month_v, year_v, epoch_v, s_v, m_v, h_v;
    logic [3:0]  wd_v;

    rtc_cal_alarm DUT (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .COUNT_TICK(COUNT_TICK), .DAY_WRAP(DAY_WRAP), .SEC_NOW(SEC_NOW), .MIN_NOW(MIN_NOW),
        .HOUR_NOW(HOUR_NOW), .WEEKDAY_NOW(WEEKDAY_NOW), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ALARM_FLAG(ALARM_FLAG), .BCD_MODE(BCD_MODE),
        .UNLOCKED(UNLOCKED), .MONTH_COUNT(MONTH_COUNT), .YEAR_COUNT(YEAR_COUNT),
        .EPOCH_COUNT(EPOCH_COUNT));

    always #4 CLK = ~CLK;

    function automatic logic [7:0] enc(input int v, input logic b);
        return b ? {4'(v / 10), 4'(v % 10)} : 8'(v);
    endfunction : enc

    task automatic close_out;
        $display("counts: %0d mismatches in %0d comparisons", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // The slave never stalls today, but the master must not assume that.
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                $display("mismatch hready_wait expected 1 seen %b", HREADYOUT);
                close_out();
            end
            @(posedge CLK);
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        HSEL   <= 1'b1;
        HTRANS <= rtc_cal_pkg::HTRANS_NONSEQ;
        HWRITE <= wr;
        HADDR  <= {{22{1'b0}}, idx, 2'b00};
        wait_ready();
        HTRANS <= 2'b00;
        HSEL   <= 1'b0;
        HWDATA <= {{24{1'b0}}, wd};
        wait_ready();
        rd = HRDATA;
        `CHK("hresp", 1'b0, HRESP)
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] ex);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        `CHK(nm, {{24{1'b0}}, ex}, r)
    endtask : rdchk

    task automatic pulse(input logic day);
        if (day)
            DAY_WRAP <= 1'b1;
        else
            COUNT_TICK <= 1'b1;
        @(posedge CLK);
        DAY_WRAP   <= 1'b0;
        COUNT_TICK <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask : pulse

    task automatic set_ctrl(input logic unl);
        wr(rtc_cal_pkg::IDX_CTRL, {2'b00, bcd, 4'h0, unl});
    endtask : set_ctrl

    initial begin
        void'($urandom(4354));
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        rdchk("unmapped", 8'h10, 8'h00);
        for (int md = 0; md < 2; md++) begin
            bcd = md[0];
            set_ctrl(1'b1);
            month_v = enc($urandom_range(12, 1), bcd);
            year_v  = enc($urandom_range(99, 0), bcd);
            epoch_v = enc($urandom_range(99, 0), bcd);
            s_v = enc($urandom_range(59, 0), bcd);
            m_v = enc($urandom_range(59, 0), bcd);
            h_v = enc($urandom_range(23, 0), bcd);
            wd_v = 4'($urandom_range(7, 1));
            wr(rtc_cal_pkg::IDX_MONTH, month_v);
            wr(rtc_cal_pkg::IDX_YEAR, year_v);
            wr(rtc_cal_pkg::IDX_EPOCH, epoch_v);
            wr(rtc_cal_pkg::IDX_ALM_WD, {4'hf, wd_v});
            rdchk("month", rtc_cal_pkg::IDX_MONTH, month_v);
            rdchk("year", rtc_cal_pkg::IDX_YEAR, year_v);
            rdchk("epoch", rtc_cal_pkg::IDX_EPOCH, epoch_v);
            rdchk("weekday", rtc_cal_pkg::IDX_ALM_WD, {4'h0, wd_v});
            `CHK("bcd_mode", bcd, BCD_MODE)
            `CHK("unlocked", 1'b1, UNLOCKED)
            set_ctrl(1'b0);
            // Alarm time set-points go in while locked; the count and weekday writes must bounce.
            wr(rtc_cal_pkg::IDX_ALM_S, s_v);
            wr(rtc_cal_pkg::IDX_ALM_M, m_v);
            wr(rtc_cal_pkg::IDX_ALM_H, h_v);
            wr(rtc_cal_pkg::IDX_MONTH, ~month_v);
            wr(rtc_cal_pkg::IDX_EPOCH, ~epoch_v);
            wr(rtc_cal_pkg::IDX_ALM_WD, 8'h00);
            wr(rtc_cal_pkg::IDX_ALM_EN, 8'h0f);
            rdchk("month_locked", rtc_cal_pkg::IDX_MONTH, month_v);
            rdchk("epoch_locked", rtc_cal_pkg::IDX_EPOCH, epoch_v);
            rdchk("wd_locked", rtc_cal_pkg::IDX_ALM_WD, {4'h0, wd_v});
            rdchk("alarm_s", rtc_cal_pkg::IDX_ALM_S, s_v);
            // A byte-sized transfer is ignored with an OKAY answer, so the set-point must not move.
            HSIZE <= 3'b000;
            wr(rtc_cal_pkg::IDX_ALM_S, ~s_v);
            HSIZE <= rtc_cal_pkg::HSIZE_WORD;
            rdchk("alarm_s_size", rtc_cal_pkg::IDX_ALM_S, s_v);
            RESET_N <= 1'b0;
            repeat (3) @(posedge CLK);
            RESET_N <= 1'b1;
            @(posedge CLK);
            rdchk("month_rst", rtc_cal_pkg::IDX_MONTH, month_v);
            rdchk("year_rst", rtc_cal_pkg::IDX_YEAR, year_v);
            rdchk("epoch_rst", rtc_cal_pkg::IDX_EPOCH, epoch_v);
            rdchk("alarm_m_rst", rtc_cal_pkg::IDX_ALM_M, m_v);
            rdchk("alarm_h_rst", rtc_cal_pkg::IDX_ALM_H, h_v);
            rdchk("wd_rst", rtc_cal_pkg::IDX_ALM_WD, {4'h0, wd_v});
            rdchk("enables_rst", rtc_cal_pkg::IDX_ALM_EN, 8'h00);
            rdchk("ctrl_rst", rtc_cal_pkg::IDX_CTRL, {2'b00, bcd, 5'h00});
            set_ctrl(1'b1);
            wr(rtc_cal_pkg::IDX_MONTH, enc(12, bcd));
            wr(rtc_cal_pkg::IDX_YEAR, enc(99, bcd));
            wr(rtc_cal_pkg::IDX_EPOCH, enc(19, bcd));
            pulse(1'b1);
            `CHK("month_halt", enc(12, bcd), MONTH_COUNT)
            set_ctrl(1'b0);
            pulse(1'b1);
            `CHK("month_wrap", enc(1, bcd), MONTH_COUNT)
            `CHK("year_wrap", enc(0, bcd), YEAR_COUNT)
            `CHK("epoch_carry", enc(20, bcd), EPOCH_COUNT)
            CE <= 1'b0;
            pulse(1'b1);
            CE <= 1'b1;
            `CHK("month_frozen", enc(1, bcd), MONTH_COUNT)
            repeat (9) pulse(1'b1);
            `CHK("month_ten", enc(10, bcd), MONTH_COUNT)
            for (int f = 0; f < 4; f++) begin
                SEC_NOW     <= enc($urandom_range(59, 0), bcd);
                MIN_NOW     <= enc($urandom_range(59, 0), bcd);
                HOUR_NOW    <= enc($urandom_range(23, 0), bcd);
                WEEKDAY_NOW <= 4'($urandom_range(7, 1));
                wr(rtc_cal_pkg::IDX_ALM_EN, 8'h00);
                set_ctrl(1'b1);
                wr(rtc_cal_pkg::IDX_ALM_S, SEC_NOW);
                wr(rtc_cal_pkg::IDX_ALM_M, MIN_NOW);
                wr(rtc_cal_pkg::IDX_ALM_H, HOUR_NOW);
                wr(rtc_cal_pkg::IDX_ALM_WD, {4'h0, WEEKDAY_NOW});
                set_ctrl(1'b0);
                pulse(1'b0);
                `CHK("flag_no_enable", 1'b0, ALARM_FLAG)
                wr(rtc_cal_pkg::IDX_ALM_EN, 8'(1 << f));
                rdchk("enables", rtc_cal_pkg::IDX_ALM_EN, 8'(1 << f));
                pulse(1'b0);
                `CHK("flag_match", 1'b1, ALARM_FLAG)
                rdchk("ctrl_flag", rtc_cal_pkg::IDX_CTRL, {2'b10, bcd, 5'h00});
                `CHK("flag_cleared", 1'b0, ALARM_FLAG)
                set_ctrl(1'b1);
                pulse(1'b0);
                `CHK("flag_unlocked", 1'b0, ALARM_FLAG)
                set_ctrl(1'b0);
                repeat (2) @(posedge CLK);
                `CHK("flag_relock", 1'b1, ALARM_FLAG)
                rdchk("ctrl_relock", rtc_cal_pkg::IDX_CTRL, {2'b10, bcd, 5'h00});
                SEC_NOW     <= ~SEC_NOW;
                MIN_NOW     <= ~MIN_NOW;
                HOUR_NOW    <= ~HOUR_NOW;
                WEEKDAY_NOW <= ~WEEKDAY_NOW;
                pulse(1'b0);
                `CHK("flag_mismatch", 1'b0, ALARM_FLAG)
            end
        end
        close_out();
    end
endmodule : tb

`undef CHK
`default_nettype wire
